//--- hw/adc_ctrl.v
// Contract
// - Sleep request high holds power-down, stops conversion.
// - Power-down makes output undefined, flushes pipeline.
// - After sleep falls, discard words 280 us.
// - Four-level select sets format and stabilizer.
// - Select change corrupts outputs for several cycles.
// - Stabilizer accepts 20 to 80 percent duty.
// - Fourteen-bit output valid only while awake.
// - Sample clock paces sampling and state machine.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"

module adc_ctrl #(
   parameter WIDTH          = 14,
   parameter DEPTH          = 16,
   parameter AW             = 4,
   parameter RECOVER_CYCLES = `RECOVER_CYCLES
)(
   // Clock and reset
   input  wire              SYS_CLK_I,
   input  wire              RESET_N_I,
   // Raw conversion core
   input  wire [WIDTH-1:0]  CORE_CODE_I,
   input  wire              CORE_STROBE_I,
   // Avalon-MM slave
   input  wire [3:0]        AVS_ADDRESS_I,
   input  wire              AVS_READ_I,
   input  wire              AVS_WRITE_I,
   input  wire [31:0]       AVS_WRITEDATA_I,
   input  wire [3:0]        AVS_BYTEENABLE_I,
   output reg  [31:0]       AVS_READDATA_O,
   output reg               AVS_WAITREQUEST_O,
   // Parallel output port
   output reg  [WIDTH-1:0]  SAMPLE_DATA_O,
   output reg               SAMPLE_VALID_O,
   output reg               SLEEP_ACTIVE_O,
   output reg               STABILIZER_ON_O
);

   // --------------------------------------------------------------------
   // State encoding
   // --------------------------------------------------------------------
   localparam [1:0] ST_SLEEP   = 2'h0;
   localparam [1:0] ST_RECOVER = 2'h1;
   localparam [1:0] ST_SETTLE  = 2'h2;
   localparam [1:0] ST_RUN     = 2'h3;

   localparam [31:0] RECOVER_LAST = RECOVER_CYCLES - 1;
   localparam [31:0] SETTLE_LAST  = `SEL_SETTLE_CYCLES - 1;
   localparam [2:0]  CTL_RESET    = `CTL_RESET_VALUE;

   function [WIDTH-1:0] format_code;
      input [WIDTH-1:0] code;
      input             twos;
      begin
         format_code = {code[WIDTH-1] ^ twos, code[WIDTH-2:0]};
      end
   endfunction

   function [1:0] decode_sel;
      input [1:0] sel;
      begin
         case (sel)
            `SEL_SUPPLY: decode_sel = 2'h1;
            `SEL_GROUND: decode_sel = 2'h3;
            `SEL_MIDREF: decode_sel = 2'h2;
            default:     decode_sel = 2'h0;
         endcase
      end
   endfunction

   // --------------------------------------------------------------------
   // Input synchronisers for the asynchronous core strobe and code
   // --------------------------------------------------------------------
   reg [WIDTH-1:0] code_s1_q;
   reg [WIDTH-1:0] code_s2_q;
   reg             strobe_s1_q;
   reg             strobe_s2_q;
   reg             strobe_s3_q;

   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         code_s1_q   <= {WIDTH{1'b0}};
         code_s2_q   <= {WIDTH{1'b0}};
         strobe_s1_q <= 1'b0;
         strobe_s2_q <= 1'b0;
         strobe_s3_q <= 1'b0;
      end
      else
      begin
         code_s1_q   <= CORE_CODE_I;
         code_s2_q   <= code_s1_q;
         strobe_s1_q <= CORE_STROBE_I;
         strobe_s2_q <= strobe_s1_q;
         strobe_s3_q <= strobe_s2_q;
      end
   end

   // One sample per rising strobe edge, all paced by the single clock.
   wire new_sample = strobe_s2_q && !strobe_s3_q;

   // --------------------------------------------------------------------
   // Control register
   // --------------------------------------------------------------------
   reg        sleep_request_q;
   reg [1:0]  format_stabilizer_select_q;
   reg [1:0]  state_q;
   reg [1:0]  state_d;
   reg [31:0] count_q;
   reg [31:0] count_d;
   reg        overrun_q;
   reg        word_accepted;

   wire       sel_write;
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [WIDTH-1:0] fifo_out_data;
   wire [AW:0]      fifo_level;
   wire [1:0]       mode = decode_sel(format_stabilizer_select_q);
   wire             twos = mode[1];

   assign sel_write = AVS_WRITE_I && AVS_WAITREQUEST_O == 1'b0
                      && AVS_ADDRESS_I == `REG_CONTROL
                      && AVS_BYTEENABLE_I[0];

   wire ctl_write = sel_write;
   wire [1:0] new_sel =
      AVS_WRITEDATA_I[`CTL_SEL_MSB:`CTL_SEL_LSB];
   wire sel_change = ctl_write && (new_sel != format_stabilizer_select_q);

   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         sleep_request_q            <= CTL_RESET[`CTL_SLEEP_BIT];
         format_stabilizer_select_q <= CTL_RESET[`CTL_SEL_MSB:`CTL_SEL_LSB];
      end
      else if (ctl_write)
      begin
         sleep_request_q            <= AVS_WRITEDATA_I[`CTL_SLEEP_BIT];
         format_stabilizer_select_q <= new_sel;
      end
   end

   // --------------------------------------------------------------------
   // Conversion state machine
   // --------------------------------------------------------------------
   always @*
   begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         ST_SLEEP:
         begin
            count_d = 32'h0;
            if (!sleep_request_q)
            begin
               state_d = ST_RECOVER;
            end
         end
         ST_RECOVER:
         begin
            count_d = count_q + 32'h1;
            if (count_q >= RECOVER_LAST)
            begin
               state_d = ST_RUN;
               count_d = 32'h0;
            end
         end
         ST_SETTLE:
         begin
            count_d = count_q + 32'h1;
            if (count_q >= SETTLE_LAST)
            begin
               state_d = ST_RUN;
               count_d = 32'h0;
            end
         end
         ST_RUN:
         begin
            count_d = 32'h0;
         end
         default:
         begin
            state_d = ST_SLEEP;
            count_d = 32'h0;
         end
      endcase
      if (sel_change && state_q != ST_SLEEP && state_q != ST_RECOVER)
      begin
         state_d = ST_SETTLE;
         count_d = 32'h0;
      end
      if (sleep_request_q)
      begin
         state_d = ST_SLEEP;
         count_d = 32'h0;
      end
   end

   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         state_q <= ST_SLEEP;
         count_q <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   wire running = (state_q == ST_RUN);

   // --------------------------------------------------------------------
   // Sample path into the FIFO
   // --------------------------------------------------------------------
   // Words are only queued while running; the rest are dropped.
   wire push_ok = new_sample && running;
   wire flush   = sleep_request_q;

   always @*
   begin
      word_accepted = push_ok && fifo_in_ready;
   end

   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         overrun_q <= 1'b0;
      end
      else if (push_ok && !fifo_in_ready)
      begin
         overrun_q <= 1'b1;
      end
      else if (ctl_write && AVS_WRITEDATA_I[31])
      begin
         overrun_q <= 1'b0;
      end
   end

   // Back-pressure: the register read of the sample word drains it.
   wire sample_read = AVS_READ_I && !AVS_WAITREQUEST_O
                      && AVS_ADDRESS_I == `REG_SAMPLE;

   sample_fifo #(
      .WIDTH       (WIDTH),
      .DEPTH       (DEPTH),
      .AW          (AW)
   ) u_fifo (
      .clk_i       (SYS_CLK_I),
      .reset_n_i   (RESET_N_I),
      .flush_i     (flush),
      .in_valid_i  (push_ok),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (format_code(code_s2_q, twos)),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (sample_read),
      .out_data_o  (fifo_out_data),
      .level_o     (fifo_level)
   );

   // --------------------------------------------------------------------
   // Registered output port
   // --------------------------------------------------------------------
   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         SAMPLE_DATA_O   <= {WIDTH{1'b0}};
         SAMPLE_VALID_O  <= 1'b0;
         SLEEP_ACTIVE_O  <= 1'b1;
         STABILIZER_ON_O <= 1'b0;
      end
      else
      begin
         // Outputs are presented for capture on the rising edge.
         if (word_accepted)
         begin
            SAMPLE_DATA_O <= format_code(code_s2_q, twos);
         end
         SAMPLE_VALID_O  <= word_accepted && !sleep_request_q;
         SLEEP_ACTIVE_O  <= sleep_request_q;
         // Duty tolerance lives in the analog core; this is its enable.
         STABILIZER_ON_O <= mode[0];
      end
   end

   // --------------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then the answer
   // --------------------------------------------------------------------
   wire req = AVS_READ_I || AVS_WRITE_I;

   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O    <= 32'h0;
      end
      else
      begin
         AVS_WAITREQUEST_O <= !(req && AVS_WAITREQUEST_O);
         if (AVS_READ_I && AVS_WAITREQUEST_O)
         begin
            case (AVS_ADDRESS_I)
               `REG_CONTROL:
                  AVS_READDATA_O <= {29'h0, format_stabilizer_select_q,
                                     sleep_request_q};
               `REG_STATUS:
                  AVS_READDATA_O <= {25'h0, !fifo_out_valid, overrun_q,
                                     mode[0], twos, running,
                                     state_q == ST_RECOVER,
                                     state_q == ST_SLEEP};
               `REG_SAMPLE:
                  AVS_READDATA_O <= {fifo_out_valid, 17'h0,
                                     fifo_out_data};
               `REG_LEVEL:
                  AVS_READDATA_O <= {{(31-AW){1'b0}}, fifo_level};
               default:
                  AVS_READDATA_O <= 32'h0;
            endcase
         end
      end
   end

endmodule // adc_ctrl

`default_nettype wire

//--- hw/adc_ctrl_map.vh
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// -----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// -----------------------------------------------------------------------
`define REG_CONTROL        4'h0
`define REG_STATUS         4'h4
`define REG_SAMPLE         4'h8
`define REG_LEVEL          4'hc

// -----------------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------------
`define CTL_SLEEP_BIT      0
`define CTL_SEL_LSB        1
`define CTL_SEL_MSB        2
`define CTL_RESET_VALUE    3'h2

// -----------------------------------------------------------------------
// Select encodings
// -----------------------------------------------------------------------
`define SEL_SUPPLY         2'h0
`define SEL_GROUND         2'h1
`define SEL_MIDREF         2'h2
`define SEL_FLOAT          2'h3

// -----------------------------------------------------------------------
// Status fields
// -----------------------------------------------------------------------
`define STS_ASLEEP_BIT     0
`define STS_RECOVER_BIT    1
`define STS_VALID_BIT      2
`define STS_TWOS_BIT       3
`define STS_STAB_BIT       4
`define STS_OVERRUN_BIT    5
`define STS_EMPTY_BIT      6

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define CLK_PERIOD_PS      4000
`define RECOVER_TIME_US    280
`define RECOVER_CYCLES     ((`RECOVER_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define SEL_SETTLE_CYCLES  8
`define PIPE_LATENCY       7
`define DUTY_MIN_PCT       20
`define DUTY_MAX_PCT       80

`endif

//--- hw/sample_mem.v
`timescale 1ns/1ps
`default_nettype none

// Simple dual-port storage; read data leave through a register.
module sample_mem #(
   parameter WIDTH = 14,
   parameter DEPTH = 16,
   parameter AW    = 4
)(
   input  wire             clk_i,
   input  wire             wr_en_i,
   input  wire [AW-1:0]    wr_addr_i,
   input  wire [WIDTH-1:0] wr_data_i,
   input  wire [AW-1:0]    rd_addr_i,
   output reg  [WIDTH-1:0] rd_data_o
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];

   always @(posedge clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule // sample_mem

`default_nettype wire

//--- hw/sample_fifo.v
`timescale 1ns/1ps
`default_nettype none

// First-word-fall-through FIFO built around the registered memory.
module sample_fifo #(
   parameter WIDTH = 14,
   parameter DEPTH = 16,
   parameter AW    = 4
)(
   input  wire             clk_i,
   input  wire             reset_n_i,
   input  wire             flush_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   output wire [AW:0]      level_o
);

   reg  [AW:0]      wr_ptr_q;
   reg  [AW:0]      rd_ptr_q;
   reg              out_valid_q;
   wire [AW:0]      count;
   wire             push;
   wire             pop;
   wire             load;
   wire             stored;
   wire [AW:0]      level;
   wire [AW-1:0]    head_addr;

   assign count       = wr_ptr_q - rd_ptr_q;
   // The output register counts towards the depth, so the whole FIFO
   // never holds more than DEPTH words.
   assign in_ready_o  = (level != DEPTH[AW:0]);
   assign push        = in_valid_i && in_ready_o;
   assign stored      = (count != {(AW+1){1'b0}});
   // The head word is fetched when the output register is free.
   assign load        = stored && (!out_valid_q || out_ready_i);
   assign pop         = out_valid_q && out_ready_i;
   assign out_valid_o = out_valid_q;
   assign level       = count + {{AW{1'b0}}, out_valid_q};
   assign level_o     = level;
   // The memory register reloads every cycle, so it keeps pointing at
   // the word now shown until a new head is fetched.
   assign head_addr   = load ? rd_ptr_q[AW-1:0]
                             : rd_ptr_q[AW-1:0] - 1'b1;

   always @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wr_ptr_q    <= {(AW+1){1'b0}};
         rd_ptr_q    <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
      end
      else if (flush_i)
      begin
         wr_ptr_q    <= {(AW+1){1'b0}};
         rd_ptr_q    <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (load)
         begin
            rd_ptr_q    <= rd_ptr_q + 1'b1;
            out_valid_q <= 1'b1;
         end
         else if (pop)
         begin
            out_valid_q <= 1'b0;
         end
      end
   end

   sample_mem #(
      .WIDTH     (WIDTH),
      .DEPTH     (DEPTH),
      .AW        (AW)
   ) u_mem (
      .clk_i     (clk_i),
      .wr_en_i   (push),
      .wr_addr_i (wr_ptr_q[AW-1:0]),
      .wr_data_i (in_data_i),
      .rd_addr_i (head_addr),
      .rd_data_o (out_data_o)
   );

endmodule // sample_fifo

`default_nettype wire

//--- verif/adc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker (
   // Clock and reset
   input wire logic        SYS_CLK_I,
   input wire logic        RESET_N_I,
   // Core and bus inputs
   input wire logic        CORE_STROBE_I,
   input wire logic [3:0]  AVS_ADDRESS_I,
   input wire logic        AVS_READ_I,
   input wire logic        AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0]  AVS_BYTEENABLE_I,
   // Outputs watched
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic        AVS_WAITREQUEST_O,
   input wire logic        SAMPLE_VALID_O,
   input wire logic        SLEEP_ACTIVE_O,
   input wire logic        STABILIZER_ON_O
);
   logic arm_q;
   logic slp_q;
   logic stab_q;
   logic wr_ctl;
   // -----------------------------------------------------------------
   // A control write is remembered so later levels can be tied to it.
   // -----------------------------------------------------------------
   assign wr_ctl = AVS_WRITE_I && !AVS_WAITREQUEST_O &&
                   AVS_ADDRESS_I == 4'h0 && AVS_BYTEENABLE_I[0];
   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         arm_q  <= 1'b0;
         slp_q  <= 1'b0;
         stab_q <= 1'b1;
      end
      else
      begin
         arm_q <= wr_ctl;
         if (wr_ctl)
         begin
            slp_q  <= AVS_WRITEDATA_I[0];
            stab_q <= AVS_WRITEDATA_I[2:1] < 2'h2;
         end
      end
   end
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   AST_SLEEP_QUIET: assert property (SLEEP_ACTIVE_O |-> !SAMPLE_VALID_O)
      else $error("valid word while asleep");
   AST_WAKE_BLANK: assert property ($fell(SLEEP_ACTIVE_O) |->
      !SAMPLE_VALID_O [*8]) else $error("word during recovery");
   AST_VALID_PULSE: assert property (SAMPLE_VALID_O |=> !SAMPLE_VALID_O)
      else $error("valid longer than one cycle");
   AST_VALID_CAUSE: assert property ($rose(SAMPLE_VALID_O) |->
      $past(CORE_STROBE_I, 3)) else $error("valid without strobe");
   AST_ACK_ONE: assert property ((AVS_READ_I || AVS_WRITE_I) &&
      AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("late ack");
   AST_ACK_SHORT: assert property (!AVS_WAITREQUEST_O |=>
      AVS_WAITREQUEST_O) else $error("ack held too long");
   AST_NO_IDLE_ACK: assert property (!(AVS_READ_I || AVS_WRITE_I) |=>
      AVS_WAITREQUEST_O) else $error("ack without request");
   AST_UNMAPPED_ZERO: assert property (AVS_READ_I && !AVS_WAITREQUEST_O &&
      AVS_ADDRESS_I[1:0] != 2'h0 |-> AVS_READDATA_O == 32'h0)
      else $error("unmapped read not zero");
   AST_STAB_SEL: assert property (arm_q |-> ##[0:12]
      STABILIZER_ON_O == stab_q) else $error("stabilizer level wrong");
   AST_SLEEP_SEL: assert property (arm_q |-> ##[0:3]
      SLEEP_ACTIVE_O == slp_q) else $error("sleep level wrong");
endmodule // adc_ctrl_checker
bind adc_ctrl adc_ctrl_checker u_adc_ctrl_checker (
   .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
   .CORE_STROBE_I(CORE_STROBE_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
   .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .SAMPLE_VALID_O(SAMPLE_VALID_O), .SLEEP_ACTIVE_O(SLEEP_ACTIVE_O),
   .STABILIZER_ON_O(STABILIZER_ON_O));
`default_nettype wire

//--- verif/adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
   // Clock, reset and command
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        go_i,
   input  wire logic [13:0] code_i,
   input  wire logic [3:0]  gap_i,
   // Core side
   output logic             busy_o,
   output logic [13:0]      core_code_o,
   output logic             core_strobe_o
);
   logic [4:0] cnt_q;
   logic [3:0] gap_q;
   assign busy_o = (cnt_q != 5'h0);
   // -----------------------------------------------------------------
   // Strobe stands seven cycles, then the code lines turn over so that a
   // late capture sees garbage rather than a lucky stale value.
   // -----------------------------------------------------------------
   always @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_q         <= 5'h0;
         gap_q         <= 4'h0;
         core_code_o   <= 14'h0;
         core_strobe_o <= 1'b0;
      end
      else if (cnt_q != 5'h0)
      begin
         cnt_q <= cnt_q - 5'h1;
         if (cnt_q == {1'b0, gap_q})
         begin
            core_strobe_o <= 1'b0;
            core_code_o   <= ~core_code_o;
         end
      end
      else if (go_i)
      begin
         core_code_o   <= code_i;
         core_strobe_o <= 1'b1;
         gap_q         <= gap_i;
         cnt_q         <= {1'b0, gap_i} + 5'h6;
      end
   end
endmodule // adc_core_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int REC = 20;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [13:0] core_code;
   logic        core_stb;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdata;
   logic        waitreq;
   logic [13:0] smp_data;
   logic        smp_valid;
   logic        sleep_act;
   logic        stab_on;
   logic        go = 1'b0;
   logic [13:0] go_code = 14'h0;
   logic [3:0]  gap = 4'h2;
   logic        busy;
   logic        lax = 1'b0;
   logic        t;
   logic [13:0] r;
   logic [13:0] arr[20];
   logic [63:0] ent;
   logic [13:0] exp_smp[$];
   logic [63:0] exp_rd[$];
   logic [13:0] tbl[4] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff};
   int          num_errors = 0;
   int          samples_checked = 0;
   int          seed = 30;
   always #2 clk = ~clk;
   adc_core_model u_adc_core_model (.clk_i(clk), .reset_n_i(rst_n),
      .go_i(go), .code_i(go_code), .gap_i(gap), .busy_o(busy),
      .core_code_o(core_code), .core_strobe_o(core_stb));
   adc_ctrl #(.RECOVER_CYCLES(REC)) u_adc_ctrl (.SYS_CLK_I(clk),
      .RESET_N_I(rst_n), .CORE_CODE_I(core_code), .CORE_STROBE_I(core_stb),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .SAMPLE_DATA_O(smp_data), .SAMPLE_VALID_O(smp_valid),
      .SLEEP_ACTIVE_O(sleep_act), .STABILIZER_ON_O(stab_on));
   function automatic logic [13:0] fmt(input logic [13:0] c, input logic f);
      return {c[13] ^ f, c[12:0]};
   endfunction
   task automatic cmp_word(input string w, input logic [31:0] e, s);
      samples_checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic cmp_flag(input string w, input logic e, s);
      samples_checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("BAD %s expected %b seen %b", w, e, s);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Bus master: the request stands until waitrequest is seen low.
   // -----------------------------------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (waitreq !== 1'b0 && k < 50);
      if (k == 50)
         num_errors++;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rd_exp(input logic [3:0] a, input logic [31:0] m, v);
      exp_rd.push_back({m, v});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic smp(input logic [13:0] c, input logic keep, input logic f);
      int k;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (busy !== 1'b0 && k < 50);
      go      <= 1'b1;
      go_code <= c;
      gap     <= 4'h2 + {1'b0, 3'($random(seed))};
      @(posedge clk);
      go <= 1'b0;
      if (keep)
         exp_smp.push_back(fmt(c, f));
   endtask
   task automatic wait_q;
      int k;
      k = 0;
      while (exp_smp.size() != 0 && k < 200)
      begin
         @(posedge clk);
         k++;
      end
      if (k == 200)
         num_errors++;
      repeat (4) @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      if (smp_valid === 1'b1 && exp_smp.size() > 0)
         cmp_word("sample", {18'h0, exp_smp.pop_front()}, {18'h0, smp_data});
      else if (smp_valid === 1'b1 && !lax)
         cmp_flag("stray word", 1'b0, 1'b1);
      if (rd === 1'b1 && waitreq === 1'b0 && exp_rd.size() > 0)
      begin
         ent = exp_rd.pop_front();
         if (ent[63:32] != 32'h0)
            cmp_word("read", ent[31:0], rdata & ent[63:32]);
      end
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      num_errors++;
      stop_test();
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_exp(4'h0, 32'h7, 32'h2);
      rd_exp(4'h4, 32'h3, 32'h2);
      smp(14'h1234, 1'b0, 1'b0);
      repeat (REC + 10) @(posedge clk);
      rd_exp(4'h4, 32'h1f, 32'h1c);
      cmp_flag("stabilizer", 1'b1, stab_on);
      rd_exp(4'h2, 32'hffffffff, 32'h0);
      bus(1'b1, 4'h1, 32'h5);
      @(posedge clk);
      be <= 4'he;
      bus(1'b1, 4'h0, 32'h7);
      be <= 4'hf;
      rd_exp(4'h0, 32'h7, 32'h2);
      $display("test reset and map done");
      for (int s = 0; s < 4; s++)
      begin
         t = (s == 1 || s == 2);
         bus(1'b1, 4'h0, s << 1);
         smp(14'h0aaa, 1'b0, t);
         repeat (12) @(posedge clk);
         cmp_flag("stabilizer", s < 2, stab_on);
         rd_exp(4'h4, 32'h18, {27'h0, s < 2, t, 3'h0});
         smp(tbl[s], 1'b1, t);
         r = 14'($random(seed));
         smp(r, 1'b1, t);
         wait_q();
         rd_exp(4'h8, 32'h80003fff, {18'h20000, fmt(tbl[s], t)});
         rd_exp(4'h8, 32'h80003fff, {18'h20000, fmt(r, t)});
      end
      $display("test formats done");
      smp(14'h0155, 1'b1, 1'b0);
      wait_q();
      bus(1'b1, 4'h0, 32'h7);
      repeat (4) @(posedge clk);
      cmp_flag("sleep", 1'b1, sleep_act);
      smp(14'h0156, 1'b0, 1'b0);
      rd_exp(4'hc, 32'h1f, 32'h0);
      bus(1'b1, 4'h0, 32'h6);
      rd_exp(4'h4, 32'h3, 32'h2);
      smp(14'h0157, 1'b0, 1'b0);
      repeat (REC + 10) @(posedge clk);
      smp(14'h0158, 1'b1, 1'b0);
      wait_q();
      rd_exp(4'h8, 32'h80003fff, 32'h80000158);
      $display("test sleep done");
      lax = 1'b1;
      for (int i = 0; i < 20; i++)
      begin
         arr[i] = 14'($random(seed));
         smp(arr[i], i < 16, 1'b0);
      end
      wait_q();
      rd_exp(4'h4, 32'h20, 32'h20);
      for (int i = 0; i < 16; i++)
         rd_exp(4'h8, 32'h80003fff, {18'h20000, arr[i]});
      rd_exp(4'h8, 32'h80000000, 32'h0);
      rd_exp(4'h8, 32'h80000000, 32'h0);
      rd_exp(4'hc, 32'h1f, 32'h0);
      rd_exp(4'h4, 32'h40, 32'h40);
      bus(1'b1, 4'h0, 32'h80000006);
      rd_exp(4'h4, 32'h20, 32'h0);
      lax = 1'b0;
      $display("test buffer done");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
